// *** verilog/kci_pkg.sv ***
// Purpose: constants, types and register map of the keypad calibration and init menu
// Assumes: 50 MHz system clock, measurement in 0.01 mA units, output current in 0.1 mA units
// Notes: long times are in milliseconds and become top-level parameters
// Contract
// - reset plus test held 2 s enters maintenance
// - maintenance leaves only on reset key press; the code also leaves when the completion message ends
// - stable in-window 4mA reading shows success, advances
// - out of window shows fail, then live again
// - 20mA step shows digits, checks like low point
// - output test starts 4.0, range 3.0-21.0mA
// - completion message 2 s then concentration display
// - select, up, down at power-on: factory restore
// - select and down at power-on: calibration restore
// - factory restore resets every stored setting
// - calibration restore resets calibration values only
// - yes/no starts no, up/down toggle
// - confirm fills digits every 0.5 s to 1111
// - confirmed yes restores, then concentration display
// - confirmed no returns, data unchanged
// - reset at confirmation returns, no fill, no restore
package kci_pkg;

  localparam int CLK_KHZ = 50_000;
  localparam int HOLD_MS = 2000;
  localparam int END_MS = 2000;
  localparam int STEP_MS = 500;
  localparam int MSG_MS = 1000;
  localparam int DEB_MS = 10;
  localparam int HOLD_CYC_DEF = HOLD_MS * CLK_KHZ;
  localparam int END_CYC_DEF = END_MS * CLK_KHZ;
  localparam int STEP_CYC_DEF = STEP_MS * CLK_KHZ;
  localparam int MSG_CYC_DEF = MSG_MS * CLK_KHZ;
  localparam int DEB_CYC_DEF = DEB_MS * CLK_KHZ;
  localparam int TMR_W = 27;
  localparam int DEB_W = 20;

  localparam logic [7:0] OUT_INIT = 8'h28;
  localparam logic [7:0] OUT_MIN = 8'h1e;
  localparam logic [7:0] OUT_MAX = 8'hd2;
  localparam logic [2:0] FILL_FIRST = 3'h1;
  localparam logic [2:0] FILL_LAST = 3'h4;

  localparam logic [31:0] LOW_WIN_RST = 32'h01a4_017c;
  localparam logic [31:0] HIGH_WIN_RST = 32'h0802_079e;

  localparam logic [5:0] REG_STATUS = 6'h00;
  localparam logic [5:0] REG_MASK = 6'h01;
  localparam logic [5:0] REG_STATE = 6'h02;
  localparam logic [5:0] REG_LOW_WIN = 6'h03;
  localparam logic [5:0] REG_HIGH_WIN = 6'h04;
  localparam logic [5:0] REG_LIVE = 6'h05;

  localparam int EV_W = 5;
  localparam int EV_MAINT = 0;
  localparam int EV_CAL_OK = 1;
  localparam int EV_CAL_FAIL = 2;
  localparam int EV_RESTORE = 3;
  localparam int EV_SEQ_DONE = 4;

  typedef enum logic [12:0] {
    ST_BOOT = 13'h0001,
    ST_NORM = 13'h0002,
    ST_LOW_TITLE = 13'h0004,
    ST_LOW_LIVE = 13'h0008,
    ST_HIGH_TITLE = 13'h0010,
    ST_HIGH_LIVE = 13'h0020,
    ST_SUCC = 13'h0040,
    ST_FAIL = 13'h0080,
    ST_OUT_TEST = 13'h0100,
    ST_DONE = 13'h0200,
    ST_RST_TITLE = 13'h0400,
    ST_RST_CHOICE = 13'h0800,
    ST_RST_FILL = 13'h1000
  } kci_state_type;

  typedef enum logic [3:0] {
    MSG_CONC = 4'h0,
    MSG_LOW_TITLE = 4'h1,
    MSG_HIGH_TITLE = 4'h2,
    MSG_LIVE = 4'h3,
    MSG_SUCCESS = 4'h4,
    MSG_CAL_FAIL = 4'h5,
    MSG_OUT = 4'h6,
    MSG_END = 4'h7,
    MSG_ALL_TITLE = 4'h8,
    MSG_CAL_TITLE = 4'h9,
    MSG_NO = 4'ha,
    MSG_YES = 4'hb,
    MSG_FILL = 4'hc,
    MSG_BLANK = 4'hf
  } kci_msg_type;

  typedef struct packed {
    logic rst_key;
    logic test_key;
    logic select_key;
    logic up_key;
    logic down_key;
  } kci_keys_type;

  typedef struct packed {
    kci_msg_type msg;
    logic [15:0] value;
    logic [2:0] fill;
  } kci_disp_type;

endpackage

// *** verilog/kci_menu.sv ***
// Purpose: front-panel maintenance and power-on restore menu with Avalon-MM register slave
// Assumes: key pins asynchronous and active high; measurement and stable flag on clk_sys_i
// Notes: storage actions leave as one-cycle pulses; the storage side does the actual restore
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps

module kci_menu import kci_pkg::*; #(
  parameter int HOLD_CYC = HOLD_CYC_DEF,
  parameter int END_CYC = END_CYC_DEF,
  parameter int STEP_CYC = STEP_CYC_DEF,
  parameter int MSG_CYC = MSG_CYC_DEF,
  parameter int DEB_CYC = DEB_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire kci_keys_type keys_i,
  input wire logic [15:0] conc_i,
  input wire logic [15:0] meas_ma_i,
  input wire logic meas_stable_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output kci_disp_type numeric_display_o,
  output logic [7:0] out_ma_o,
  output logic menu_active_o,
  output logic cal_low_store_o,
  output logic cal_high_store_o,
  output logic restore_all_o,
  output logic restore_cal_o
);

  ////////////////////////////////////////////////////////////////////////////
  // key synchroniser and debounce

  kci_keys_type sync1_q, sync2_q, level_q, level_prev_q;
  wire kci_keys_type press = level_q & ~level_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_key
      logic [DEB_W-1:0] deb_q;
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          level_q[gi] <= 1'b0;
          deb_q <= '0;
        end else begin
          sync1_q[gi] <= keys_i[gi];
          sync2_q[gi] <= sync1_q[gi];
          if (sync2_q[gi] == level_q[gi]) begin
            deb_q <= '0;
          end else if (deb_q == DEB_W'(DEB_CYC - 1)) begin
            level_q[gi] <= sync2_q[gi];
            deb_q <= '0;
          end else begin
            deb_q <= deb_q + 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_prev_q <= '0;
    end else begin
      level_prev_q <= level_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // menu state machine

  kci_state_type state_q, state_d;
  logic [TMR_W-1:0] timer_q, timer_d;
  logic hi_q, hi_d;
  logic kind_all_q, kind_all_d;
  logic yes_q, yes_d;
  logic [2:0] fill_q, fill_d;
  logic [7:0] out_q, out_d;
  logic [EV_W-1:0] ev;
  logic low_store_d, high_store_d, rst_all_d, rst_cal_d;
  logic [31:0] low_win_q, high_win_q;

  wire both_held = level_q.rst_key & level_q.test_key;
  wire low_ok = meas_stable_i & (meas_ma_i >= low_win_q[15:0]) & (meas_ma_i <= low_win_q[31:16]);
  wire high_ok = meas_stable_i & (meas_ma_i >= high_win_q[15:0]) & (meas_ma_i <= high_win_q[31:16]);
  wire boot_done = timer_q == TMR_W'(2 * DEB_CYC + 1);
  wire hold_done = timer_q == TMR_W'(HOLD_CYC - 1);
  wire end_done = timer_q == TMR_W'(END_CYC - 1);
  wire msg_done = timer_q == TMR_W'(MSG_CYC - 1);
  wire step_done = timer_q == TMR_W'(STEP_CYC - 1);
  wire boot_all = level_q.select_key & level_q.up_key & level_q.down_key;
  wire boot_cal = level_q.select_key & ~level_q.up_key & level_q.down_key;

  always_comb begin
    state_d = state_q;
    hi_d = hi_q;
    kind_all_d = kind_all_q;
    yes_d = yes_q;
    fill_d = fill_q;
    out_d = out_q;
    ev = '0;
    low_store_d = 1'b0;
    high_store_d = 1'b0;
    rst_all_d = 1'b0;
    rst_cal_d = 1'b0;
    case (state_q)
      ST_BOOT: begin
        if (boot_done) begin
          kind_all_d = boot_all;
          if (boot_all) begin
            state_d = ST_RST_TITLE;
          end else if (boot_cal) begin
            state_d = ST_RST_TITLE;
          end else begin
            state_d = ST_NORM;
          end
        end
      end
      ST_NORM: begin
        if (both_held && hold_done) begin
          state_d = ST_LOW_TITLE;
          ev[EV_MAINT] = 1'b1;
        end
      end
      ST_LOW_TITLE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          state_d = ST_LOW_LIVE;
        end
      end
      ST_LOW_LIVE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          hi_d = 1'b0;
          if (low_ok) begin
            state_d = ST_SUCC;
            low_store_d = 1'b1;
            ev[EV_CAL_OK] = 1'b1;
          end else begin
            state_d = ST_FAIL;
            ev[EV_CAL_FAIL] = 1'b1;
          end
        end
      end
      ST_HIGH_TITLE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          state_d = ST_HIGH_LIVE;
        end
      end
      ST_HIGH_LIVE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          hi_d = 1'b1;
          if (high_ok) begin
            state_d = ST_SUCC;
            high_store_d = 1'b1;
            ev[EV_CAL_OK] = 1'b1;
          end else begin
            state_d = ST_FAIL;
            ev[EV_CAL_FAIL] = 1'b1;
          end
        end
      end
      ST_SUCC: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (msg_done) begin
          state_d = hi_q ? ST_OUT_TEST : ST_HIGH_TITLE;
          out_d = OUT_INIT;
        end
      end
      ST_FAIL: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (msg_done) begin
          state_d = hi_q ? ST_HIGH_LIVE : ST_LOW_LIVE;
        end
      end
      ST_OUT_TEST: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          state_d = ST_DONE;
        end else if (press.up_key && out_q < OUT_MAX) begin
          out_d = out_q + 8'h01;
        end else if (press.down_key && out_q > OUT_MIN) begin
          out_d = out_q - 8'h01;
        end
      end
      ST_DONE: begin
        if (end_done) begin
          state_d = ST_NORM;
          ev[EV_SEQ_DONE] = 1'b1;
        end
      end
      ST_RST_TITLE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          state_d = ST_RST_CHOICE;
          yes_d = 1'b0;
        end
      end
      ST_RST_CHOICE: begin
        if (press.rst_key) begin
          state_d = ST_NORM;
        end else if (press.select_key) begin
          state_d = ST_RST_FILL;
          fill_d = FILL_FIRST;
        end else if (press.up_key || press.down_key) begin
          yes_d = ~yes_q;
        end
      end
      ST_RST_FILL: begin
        if (step_done) begin
          if (fill_q == FILL_LAST) begin
            state_d = ST_NORM;
            if (yes_q) begin
              rst_all_d = kind_all_q;
              rst_cal_d = ~kind_all_q;
              ev[EV_RESTORE] = 1'b1;
            end
          end else begin
            fill_d = fill_q + 3'h1;
          end
        end
      end
      default: begin
        state_d = ST_NORM;
      end
    endcase
  end

  // the hold count restarts whenever either key is let go
  wire timer_clr = (state_d != state_q) || (state_q == ST_NORM && !both_held) ||
                   (state_q == ST_RST_FILL && step_done);

  always_comb begin
    timer_d = timer_clr ? '0 : timer_q + 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_BOOT;
      timer_q <= '0;
      hi_q <= 1'b0;
      kind_all_q <= 1'b0;
      yes_q <= 1'b0;
      fill_q <= '0;
      out_q <= OUT_INIT;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      hi_q <= hi_d;
      kind_all_q <= kind_all_d;
      yes_q <= yes_d;
      fill_q <= fill_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display and storage outputs

  kci_disp_type disp_d;

  always_comb begin
    disp_d.msg = MSG_CONC;
    disp_d.value = conc_i;
    disp_d.fill = '0;
    case (state_q)
      ST_BOOT: disp_d.msg = MSG_BLANK;
      ST_NORM: disp_d.msg = MSG_CONC;
      ST_LOW_TITLE: disp_d.msg = MSG_LOW_TITLE;
      ST_HIGH_TITLE: disp_d.msg = MSG_HIGH_TITLE;
      ST_LOW_LIVE, ST_HIGH_LIVE: begin
        disp_d.msg = MSG_LIVE;
        disp_d.value = meas_ma_i;
      end
      ST_SUCC: disp_d.msg = MSG_SUCCESS;
      ST_FAIL: disp_d.msg = MSG_CAL_FAIL;
      ST_OUT_TEST: begin
        disp_d.msg = MSG_OUT;
        disp_d.value = {8'h00, out_q};
      end
      ST_DONE: disp_d.msg = MSG_END;
      ST_RST_TITLE: disp_d.msg = kind_all_q ? MSG_ALL_TITLE : MSG_CAL_TITLE;
      ST_RST_CHOICE: disp_d.msg = yes_q ? MSG_YES : MSG_NO;
      ST_RST_FILL: begin
        disp_d.msg = MSG_FILL;
        disp_d.fill = fill_q;
      end
      default: disp_d.msg = MSG_BLANK;
    endcase
  end

  wire in_menu = !(state_q == ST_NORM || state_q == ST_BOOT);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      numeric_display_o <= '{msg: MSG_BLANK, value: 16'h0000, fill: 3'h0};
      out_ma_o <= OUT_INIT;
      menu_active_o <= 1'b0;
      cal_low_store_o <= 1'b0;
      cal_high_store_o <= 1'b0;
      restore_all_o <= 1'b0;
      restore_cal_o <= 1'b0;
    end else begin
      numeric_display_o <= disp_d;
      out_ma_o <= out_q;
      menu_active_o <= in_menu;
      cal_low_store_o <= low_store_d;
      cal_high_store_o <= high_store_d;
      restore_all_o <= rst_all_d;
      restore_cal_o <= rst_cal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer

  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[7:2] == idx);
  endfunction

  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [EV_W-1:0] status_q, mask_q;
  wire req = avs_read_i | avs_write_i;
  wire wr_now = avs_write_i & ack_q;
  wire wr_status = wr_now & reg_hit(avs_address_i, REG_STATUS);
  wire wr_mask = wr_now & reg_hit(avs_address_i, REG_MASK);
  wire wr_low = wr_now & reg_hit(avs_address_i, REG_LOW_WIN);
  wire wr_high = wr_now & reg_hit(avs_address_i, REG_HIGH_WIN);
  wire [EV_W-1:0] clr_bits = wr_status ? avs_writedata_i[EV_W-1:0] : '0;
  // an event in the clearing cycle survives the clear
  wire [EV_W-1:0] status_d = (status_q & ~clr_bits) | ev;

  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q) begin
      rdata_d = 32'h0000_0000;
      if (reg_hit(avs_address_i, REG_STATUS)) rdata_d = {27'h0, status_q};
      if (reg_hit(avs_address_i, REG_MASK)) rdata_d = {27'h0, mask_q};
      if (reg_hit(avs_address_i, REG_STATE)) rdata_d = {19'h0, state_q};
      if (reg_hit(avs_address_i, REG_LOW_WIN)) rdata_d = low_win_q;
      if (reg_hit(avs_address_i, REG_HIGH_WIN)) rdata_d = high_win_q;
      if (reg_hit(avs_address_i, REG_LIVE)) rdata_d = {out_q, 8'h00, meas_ma_i};
    end
  end

  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o = rdata_q;
  assign irq_o = |(status_q & mask_q);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      status_q <= '0;
      mask_q <= '0;
      low_win_q <= LOW_WIN_RST;
      high_win_q <= HIGH_WIN_RST;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      status_q <= status_d;
      if (wr_mask) mask_q <= avs_writedata_i[EV_W-1:0];
      if (wr_low) low_win_q <= avs_writedata_i;
      if (wr_high) high_win_q <= avs_writedata_i;
    end
  end

endmodule // kci_menu

// *** tb/kci_panel_model.sv ***
// Purpose: operator panel model, turns the operator's intent into bouncing key contacts
// Assumes: hand_i is the set of keys the operator holds, sampled on clk_sys_i
// Notes: every change bounces between the old and new levels for five cycles
`timescale 1ns/100ps
module kci_panel_model import kci_pkg::*; (
  input wire logic clk_sys_i,
  input wire kci_keys_type hand_i,
  output kci_keys_type keys_o = '0
);
  kci_keys_type now_q = '0;
  kci_keys_type old_q = '0;
  logic [2:0] cnt_q = 3'h0;
  ////////////////////////////////////////
  // contact bounce, no kinder than real switches
  always @(posedge clk_sys_i) begin
    if (hand_i != now_q) begin
      old_q <= now_q;
      now_q <= hand_i;
      cnt_q <= 3'h5;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
    keys_o <= cnt_q[0] ? old_q : now_q;
  end
endmodule // kci_panel_model

// *** tb/kci_menu_monitor.sv ***
// Purpose: port checker for the keypad menu block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into every kci_menu instance
`timescale 1ns/100ps
module kci_menu_monitor import kci_pkg::*; #(
  parameter int END_CYC = END_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire kci_disp_type numeric_display_o,
  input wire logic [7:0] out_ma_o,
  input wire logic menu_active_o,
  input wire logic cal_low_store_o,
  input wire logic restore_all_o,
  input wire logic restore_cal_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [31:0] end_cnt_q;
  wire logic restore_pulse = restore_all_o || restore_cal_o;
  // cycles the completion message has been shown so far
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_cnt_q <= 32'h0;
    end else begin
      end_cnt_q <= (numeric_display_o.msg == MSG_END) ? end_cnt_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////
  a_out_range: assert property (out_ma_o >= OUT_MIN && out_ma_o <= OUT_MAX)
    else $error("output test current out of range");
  a_fill_range: assert property (numeric_display_o.fill <= FILL_LAST)
    else $error("fill count above four digits");
  a_fill_step: assert property ($changed(numeric_display_o.fill) && numeric_display_o.fill != 3'h0
    |-> numeric_display_o.fill == $past(numeric_display_o.fill) + 3'h1) else $error("fill skipped a digit");
  a_restore_once: assert property (restore_pulse |=> !restore_pulse)
    else $error("restore pulse longer than one cycle");
  a_restore_excl: assert property (!(restore_all_o && restore_cal_o))
    else $error("both restore kinds at once");
  a_restore_exit: assert property (restore_pulse |-> ##[0:2] !menu_active_o)
    else $error("menu still active after restore");
  a_low_success: assert property (cal_low_store_o |-> ##[0:2] numeric_display_o.msg == MSG_SUCCESS)
    else $error("low store without success message");
  a_end_time: assert property ($fell(numeric_display_o.msg == MSG_END)
    |-> end_cnt_q >= END_CYC - 1 && end_cnt_q <= END_CYC + 1) else $error("completion message wrong length");
endmodule // kci_menu_monitor

bind kci_menu kci_menu_monitor #(.END_CYC(END_CYC)) u_kci_menu_monitor (.clk_sys_i, .rst_n_i,
  .numeric_display_o, .out_ma_o, .menu_active_o, .cal_low_store_o, .restore_all_o, .restore_cal_o);

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the keypad menu block
// Assumes: shortened timing parameters, panel model adds key bounce
// Notes: registers are reached through Avalon-MM tasks
`timescale 1ns/100ps
module testbench import kci_pkg::*;;
  localparam logic [7:0] A_STS = {REG_STATUS, 2'b00};
  localparam logic [7:0] A_MSK = {REG_MASK, 2'b00};
  localparam logic [7:0] A_STA = {REG_STATE, 2'b00};
  localparam logic [4:0] K_RST = 5'h10, K_TST = 5'h08, K_SEL = 5'h04, K_UP = 5'h02, K_DN = 5'h01;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  kci_keys_type hand = '0;
  kci_keys_type keys;
  logic [15:0] conc = 16'h1234;
  logic [15:0] meas = 16'h0;
  logic stable = 1'b0;
  logic [7:0] addr = 8'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_o, irq, cl, ch, act, ra, rc;
  kci_disp_type disp;
  logic [7:0] out_ma;
  logic [4:0] fill_seen = 5'h0;
  int num_errors = 0;
  int checks = 0;
  int n_ra, n_rc, n_cl, n_ch;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
  initial forever #10 clk_sys_i = ~clk_sys_i;
  kci_panel_model u_kci_panel_model (.clk_sys_i(clk_sys_i), .hand_i(hand), .keys_o(keys));
  kci_menu #(.HOLD_CYC(40), .END_CYC(40), .STEP_CYC(16), .MSG_CYC(20), .DEB_CYC(4)) u_kci_menu (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .keys_i(keys), .conc_i(conc), .meas_ma_i(meas),
    .meas_stable_i(stable), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .irq_o(irq), .numeric_display_o(disp),
    .out_ma_o(out_ma), .menu_active_o(act), .cal_low_store_o(cl), .cal_high_store_o(ch),
    .restore_all_o(ra), .restore_cal_o(rc));
  always @(posedge clk_sys_i) begin
    n_ra += (ra === 1'b1);
    n_rc += (rc === 1'b1);
    n_cl += (cl === 1'b1);
    n_ch += (ch === 1'b1);
    fill_seen[disp.fill] <= 1'b1;
  end
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i iff wait_o === 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, ex, q)
  endtask
  task automatic press(input logic [4:0] k, input int hold = 20);
    repeat (14) @(posedge clk_sys_i);
    hand <= k;
    repeat (hold) @(posedge clk_sys_i);
    hand <= '0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic power_on(input logic [4:0] k);
    hand <= k;
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    n_ra = 0;
    n_rc = 0;
    n_cl = 0;
    n_ch = 0;
    repeat (40) @(posedge clk_sys_i);
    hand <= '0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic cal_try(input logic [15:0] m, input logic s, input kci_msg_type ex);
    meas <= m;
    stable <= s;
    press(K_SEL);
    `CHK("verdict", ex, disp.msg)
    repeat (30) @(posedge clk_sys_i);
  endtask
  task automatic restore_run(input logic [4:0] k, input kci_msg_type ttl, input logic yes, input logic abort,
                             input int ea, input int ec);
    power_on(k);
    chk_rd("title state", A_STA, ST_RST_TITLE);
    `CHK("title", ttl, disp.msg)
    press(K_SEL);
    `CHK("choice", MSG_NO, disp.msg)
    if (yes) begin
      press(K_UP);
      `CHK("yes", MSG_YES, disp.msg)
      press(K_DN);
      `CHK("no", MSG_NO, disp.msg)
      press(K_UP);
    end
    fill_seen = 5'h0;
    press(abort ? K_RST : K_SEL);
    if (abort) chk_rd("abort", A_STA, ST_NORM);
    repeat (100) @(posedge clk_sys_i);
    `CHK("fill", abort ? 5'h01 : 5'h1f, fill_seen)
    `CHK("restore all", ea, n_ra)
    `CHK("restore cal", ec, n_rc)
    chk_rd("back", A_STA, ST_NORM);
    chk_rd("restore flag", A_STS, (ea + ec != 0) ? 32'h8 : 32'h0);
    $display("restore test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    num_errors++;
    $display("watchdog expired");
    wrap_up;
  end
  initial begin
    restore_run(K_SEL | K_UP | K_DN, MSG_ALL_TITLE, 1'b1, 1'b0, 1, 0);
    restore_run(K_SEL | K_DN, MSG_CAL_TITLE, 1'b1, 1'b0, 0, 1);
    restore_run(K_SEL | K_DN, MSG_CAL_TITLE, 1'b0, 1'b0, 0, 0);
    restore_run(K_SEL | K_UP | K_DN, MSG_ALL_TITLE, 1'b1, 1'b1, 0, 0);
    power_on(5'h0);
    conc <= 16'h0567;
    chk_rd("boot", A_STA, ST_NORM);
    `CHK("conc", 16'h0567, disp.value)
    `CHK("menu idle", 1'b0, act)
    chk_rd("mask", A_MSK, 32'h0);
    chk_rd("low win", {REG_LOW_WIN, 2'b00}, LOW_WIN_RST);
    chk_rd("high win", {REG_HIGH_WIN, 2'b00}, HIGH_WIN_RST);
    chk_rd("unmapped", 8'h3c, 32'h0);
    wr32(A_STA, 32'hffff);
    chk_rd("read only", A_STA, ST_NORM);
    wr32(A_MSK, 32'h1f);
    chk_rd("mask rw", A_MSK, 32'h1f);
    repeat (2) press(K_RST | K_TST, 30);
    chk_rd("short hold", A_STA, ST_NORM);
    press(K_RST | K_TST, 70);
    chk_rd("enter", A_STA, ST_LOW_TITLE);
    `CHK("irq", 1'b1, irq)
    `CHK("menu active", 1'b1, act)
    repeat (300) @(posedge clk_sys_i);
    chk_rd("no timeout", A_STA, ST_LOW_TITLE);
    meas <= 16'h0100;
    stable <= 1'b1;
    press(K_SEL);
    `CHK("live", 16'h0100, disp.value)
    cal_try(16'h0100, 1'b1, MSG_CAL_FAIL);
    chk_rd("retry", A_STA, ST_LOW_LIVE);
    cal_try(16'h0190, 1'b0, MSG_CAL_FAIL);
    cal_try(16'h01a4, 1'b1, MSG_SUCCESS);
    chk_rd("low next", A_STA, ST_HIGH_TITLE);
    `CHK("low store", 1, n_cl)
    press(K_SEL);
    `CHK("high digits", 16'h01a4, disp.value)
    cal_try(16'h0803, 1'b1, MSG_CAL_FAIL);
    cal_try(16'h0802, 1'b1, MSG_SUCCESS);
    chk_rd("out test", A_STA, ST_OUT_TEST);
    `CHK("out start", 8'h28, out_ma)
    `CHK("high store", 1, n_ch)
    repeat (12) press(K_DN);
    `CHK("out min", 8'h1e, out_ma)
    repeat (190) press(K_UP);
    `CHK("out max", 8'hd2, out_ma)
    press(K_SEL);
    repeat (20) @(posedge clk_sys_i);
    chk_rd("done", A_STA, ST_DONE);
    repeat (25) @(posedge clk_sys_i);
    chk_rd("end", A_STA, ST_NORM);
    chk_rd("status", A_STS, 32'h17);
    wr32(A_STS, 32'h17);
    chk_rd("cleared", A_STS, 32'h0);
    `CHK("irq off", 1'b0, irq)
    wr32(A_MSK, 32'h0);
    press(K_RST | K_TST, 70);
    `CHK("irq masked", 1'b0, irq)
    press(K_RST);
    chk_rd("exit", A_STA, ST_NORM);
    `CHK("menu left", 1'b0, act)
    $display("maintenance test done");
    wrap_up;
  end
endmodule // testbench
